// ### logic/crb_crossbar_route_enables.sv
`timescale 1ns/100ps
`default_nettype none
`include "crb_map.svh"

module crb_crossbar_route_enables (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_reset_n,
    input  wire logic [7:0]               i_sfr_page,
    input  wire logic [7:0]               i_sfr_addr,
    input  wire logic                     i_sfr_wr,
    input  wire logic                     i_sfr_rd,
    input  wire logic [7:0]               i_sfr_wdata,
    output logic                          o_sfr_sel,
    output logic [7:0]                    o_sfr_rdata,
    input  wire logic                     i_crossbar_global_en,
    input  wire logic [`CRB_PIN_COUNT-1:0] i_pin_skip_mask,
    input  wire logic                     i_spi_four_wire,
    output crb_pkg::crb_route_t           o_route,
    output crb_pkg::crb_pin_map_t         o_pin_map,
    output logic                          o_assign_overflow
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic crb_hit(input logic [7:0] page,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
        crb_hit = (page == `CRB_SFR_PAGE) && (addr == target);
    endfunction : crb_hit

    // thermometer of routed module outputs; reserved code routes none
    function automatic logic [5:0] crb_mod_mask(input logic [2:0] sel);
        logic [5:0] m;
        m = 6'h00;
        if (sel != `CRB_MOD_RESERVED) begin
            for (int i = 0; i < `CRB_MOD_COUNT; i++) begin
                m[i] = (3'(i) < sel);
            end
        end
        crb_mod_mask = m;
    endfunction : crb_mod_mask

    // priority order of the pin-seeking signals
    localparam crb_pkg::crb_func_t SLOT_FN [`CRB_SLOT_COUNT] = '{
        crb_pkg::CRB_FN_SPI_SCK,  crb_pkg::CRB_FN_SPI_MISO, crb_pkg::CRB_FN_SPI_MOSI,
        crb_pkg::CRB_FN_SPI_NSS,  crb_pkg::CRB_FN_TW_SDA,   crb_pkg::CRB_FN_TW_SCL,
        crb_pkg::CRB_FN_CMP0,     crb_pkg::CRB_FN_CMP0_ASY, crb_pkg::CRB_FN_CMP1,
        crb_pkg::CRB_FN_CMP1_ASY, crb_pkg::CRB_FN_SYSCLK,   crb_pkg::CRB_FN_MOD0,
        crb_pkg::CRB_FN_MOD1,     crb_pkg::CRB_FN_MOD2,     crb_pkg::CRB_FN_MOD3,
        crb_pkg::CRB_FN_MOD4,     crb_pkg::CRB_FN_MOD5,     crb_pkg::CRB_FN_EXT_CNT,
        crb_pkg::CRB_FN_TIMER0,   crb_pkg::CRB_FN_TIMER1
    };

    crb_pkg::crb_state_t state;
    crb_pkg::crb_state_t next_state;

    logic                       hit_a;
    logic                       hit_b;
    crb_pkg::crb_route_t        route;
    logic [`CRB_SLOT_COUNT-1:0] slot_req;
    logic [`CRB_PIN_COUNT-1:0]  taken;
    crb_pkg::crb_pin_map_t      map;
    logic                       placed;
    logic                       lost;

    assign hit_a     = crb_hit(i_sfr_page, i_sfr_addr, `CRB_ADDR_ENABLE_A);
    assign hit_b     = crb_hit(i_sfr_page, i_sfr_addr, `CRB_ADDR_ENABLE_B);
    assign o_sfr_sel = hit_a | hit_b;

    // ------------------------------------------------------------------
    // effective enables
    // ------------------------------------------------------------------
    always_comb begin
        route = '0;
        if (i_crossbar_global_en) begin
            route.cmp1_async_out_en        = state.enable_a.cmp1_async_out_en;
            route.cmp1_sync_out_en         = state.enable_a.cmp1_sync_out_en;
            route.cmp0_async_out_en        = state.enable_a.cmp0_async_out_en;
            route.cmp0_sync_out_en         = state.enable_a.cmp0_sync_out_en;
            route.twowire_bus_route_en     = state.enable_a.twowire_bus_route_en;
            route.serial_periph_route_en   = state.enable_a.serial_periph_route_en;
            route.can_route_en             = state.enable_a.can_route_en;
            route.uart_a_route_en          = state.enable_a.uart_a_route_en;
            route.timer_one_input_en       = state.enable_b.timer_one_input_en;
            route.timer_zero_input_en      = state.enable_b.timer_zero_input_en;
            route.count_array_ext_input_en = state.enable_b.count_array_ext_input_en;
            route.count_module_out_en      =
                crb_mod_mask(state.enable_b.count_array_module_out_sel);
            route.sysclk_out_en            = state.enable_b.sysclk_out_en;
        end
    end

    // ------------------------------------------------------------------
    // slot requests in priority order
    // ------------------------------------------------------------------
    always_comb begin
        slot_req      = '0;
        slot_req[0]   = route.serial_periph_route_en;
        slot_req[1]   = route.serial_periph_route_en;
        slot_req[2]   = route.serial_periph_route_en;
        slot_req[3]   = route.serial_periph_route_en & i_spi_four_wire;
        slot_req[4]   = route.twowire_bus_route_en;
        slot_req[5]   = route.twowire_bus_route_en;
        slot_req[6]   = route.cmp0_sync_out_en;
        slot_req[7]   = route.cmp0_async_out_en;
        slot_req[8]   = route.cmp1_sync_out_en;
        slot_req[9]   = route.cmp1_async_out_en;
        slot_req[10]  = route.sysclk_out_en;
        slot_req[16:11] = route.count_module_out_en;
        slot_req[17]  = route.count_array_ext_input_en;
        slot_req[18]  = route.timer_zero_input_en;
        slot_req[19]  = route.timer_one_input_en;
    end

    // ------------------------------------------------------------------
    // priority pin assignment
    // ------------------------------------------------------------------
    // a flat ripple through all slots and pins: long combinational path,
    // but the result is registered and only changes on configuration
    always_comb begin
        taken  = i_pin_skip_mask;
        map    = {`CRB_PIN_COUNT{crb_pkg::CRB_FN_GPIO}};
        lost   = 1'b0;
        placed = 1'b0;
        if (route.uart_a_route_en) begin
            map[`CRB_PIN_UART_TX]   = crb_pkg::CRB_FN_UART_TX;
            map[`CRB_PIN_UART_RX]   = crb_pkg::CRB_FN_UART_RX;
            taken[`CRB_PIN_UART_TX] = 1'b1;
            taken[`CRB_PIN_UART_RX] = 1'b1;
        end
        if (route.can_route_en) begin
            map[`CRB_PIN_CAN_TX]    = crb_pkg::CRB_FN_CAN_TX;
            map[`CRB_PIN_CAN_RX]    = crb_pkg::CRB_FN_CAN_RX;
            taken[`CRB_PIN_CAN_TX]  = 1'b1;
            taken[`CRB_PIN_CAN_RX]  = 1'b1;
        end
        for (int s = 0; s < `CRB_SLOT_COUNT; s++) begin
            placed = 1'b0;
            if (slot_req[s]) begin
                for (int p = 0; p < `CRB_PIN_COUNT; p++) begin
                    if (!placed && !taken[p]) begin
                        map[p]   = SLOT_FN[s];
                        taken[p] = 1'b1;
                        placed   = 1'b1;
                    end
                end
                if (!placed) begin
                    lost = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state          = state;
        next_state.route    = route;
        next_state.pin_map  = map;
        next_state.overflow = lost;
        if (i_sfr_wr && hit_a) begin
            next_state.enable_a = crb_pkg::crb_enable_a_t'(i_sfr_wdata);
        end
        if (i_sfr_wr && hit_b) begin
            next_state.enable_b = crb_pkg::crb_enable_b_t'(i_sfr_wdata);
            next_state.enable_b.reserved = 1'b0;
        end
        if (i_sfr_rd) begin
            if (hit_a) begin
                next_state.rdata = state.enable_a;
            end else if (hit_b) begin
                next_state.rdata = state.enable_b;
            end else begin
                next_state.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state          <= '0;
            state.enable_a <= `CRB_RESET_A;
            state.enable_b <= `CRB_RESET_B;
        end else begin
            state <= next_state;
        end
    end

    assign o_sfr_rdata       = state.rdata;
    assign o_route           = state.route;
    assign o_pin_map         = state.pin_map;
    assign o_assign_overflow = state.overflow;

endmodule : crb_crossbar_route_enables

`default_nettype wire

// ### logic/crb_map.svh
// Behaviour
// - first register bit 7 routes comparator-one async output
// - first register bit 6 routes comparator-one sync output
// - first register bit 5 routes comparator-zero async output
// - first register bit 4 routes comparator-zero sync output
// - first register bit 3 routes both two-wire signals
// - first register bit 2 routes spi, three or four pins
// - first register bit 1 fixes can on P0.6/P0.7
// - first register bit 0 fixes uart on P0.4/P0.5
// - cleared enable leaves signal on no pin
// - second register bit 7 routes timer-one input
// - second register bit 6 routes timer-zero input
// - second register bit 5 routes counter external input
// - bits 4:2 count module outputs; 111 reserved
// - second register bit 1 drives system clock out
// - first register at 0xE1 on page 0x0F
// - second register at 0xE2 on page 0x0F
// - enabled resource other than uart and can takes lowest free unskipped pin
// - nothing routed until global crossbar enable set
`ifndef CRB_MAP_SVH
`define CRB_MAP_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define CRB_SFR_PAGE        8'h0F
`define CRB_ADDR_ENABLE_A   8'hE1
`define CRB_ADDR_ENABLE_B   8'hE2
`define CRB_RESET_A         8'h00
`define CRB_RESET_B         8'h00

// ----------------------------------------------------------------------
// field positions of the second register
// ----------------------------------------------------------------------
`define CRB_B_MOD_MSB       4
`define CRB_B_MOD_LSB       2
`define CRB_B_RSVD_BIT      0
`define CRB_MOD_RESERVED    3'h7
`define CRB_MOD_COUNT       6

// ----------------------------------------------------------------------
// pin space
// ----------------------------------------------------------------------
`define CRB_PIN_COUNT       16
`define CRB_PIN_UART_TX     4
`define CRB_PIN_UART_RX     5
`define CRB_PIN_CAN_TX      6
`define CRB_PIN_CAN_RX      7
`define CRB_SLOT_COUNT      20

`endif

// ### logic/crb_pkg.sv
`include "crb_map.svh"

package crb_pkg;

    typedef enum logic [4:0] {
        CRB_FN_GPIO     = 5'h00,
        CRB_FN_UART_TX  = 5'h01,
        CRB_FN_UART_RX  = 5'h02,
        CRB_FN_CAN_TX   = 5'h03,
        CRB_FN_CAN_RX   = 5'h04,
        CRB_FN_SPI_SCK  = 5'h05,
        CRB_FN_SPI_MISO = 5'h06,
        CRB_FN_SPI_MOSI = 5'h07,
        CRB_FN_SPI_NSS  = 5'h08,
        CRB_FN_TW_SDA   = 5'h09,
        CRB_FN_TW_SCL   = 5'h0A,
        CRB_FN_CMP0     = 5'h0B,
        CRB_FN_CMP0_ASY = 5'h0C,
        CRB_FN_CMP1     = 5'h0D,
        CRB_FN_CMP1_ASY = 5'h0E,
        CRB_FN_SYSCLK   = 5'h0F,
        CRB_FN_MOD0     = 5'h10,
        CRB_FN_MOD1     = 5'h11,
        CRB_FN_MOD2     = 5'h12,
        CRB_FN_MOD3     = 5'h13,
        CRB_FN_MOD4     = 5'h14,
        CRB_FN_MOD5     = 5'h15,
        CRB_FN_EXT_CNT  = 5'h16,
        CRB_FN_TIMER0   = 5'h17,
        CRB_FN_TIMER1   = 5'h18
    } crb_func_t;

    typedef struct packed {
        logic cmp1_async_out_en;
        logic cmp1_sync_out_en;
        logic cmp0_async_out_en;
        logic cmp0_sync_out_en;
        logic twowire_bus_route_en;
        logic serial_periph_route_en;
        logic can_route_en;
        logic uart_a_route_en;
    } crb_enable_a_t;

    typedef struct packed {
        logic       timer_one_input_en;
        logic       timer_zero_input_en;
        logic       count_array_ext_input_en;
        logic [2:0] count_array_module_out_sel;
        logic       sysclk_out_en;
        logic       reserved;
    } crb_enable_b_t;

    // effective routing, already gated by the global enable
    typedef struct packed {
        logic       cmp1_async_out_en;
        logic       cmp1_sync_out_en;
        logic       cmp0_async_out_en;
        logic       cmp0_sync_out_en;
        logic       twowire_bus_route_en;
        logic       serial_periph_route_en;
        logic       can_route_en;
        logic       uart_a_route_en;
        logic       timer_one_input_en;
        logic       timer_zero_input_en;
        logic       count_array_ext_input_en;
        logic [5:0] count_module_out_en;
        logic       sysclk_out_en;
    } crb_route_t;

    typedef crb_func_t [`CRB_PIN_COUNT-1:0] crb_pin_map_t;

    typedef struct packed {
        crb_enable_a_t enable_a;
        crb_enable_b_t enable_b;
        logic [7:0]    rdata;
        crb_route_t    route;
        crb_pin_map_t  pin_map;
        logic          overflow;
    } crb_state_t;

endpackage : crb_pkg

// ### tb/crb_crossbar_route_enables_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "crb_map.svh"
module crb_route_sva (
    input wire logic                      i_core_clk,
    input wire logic                      i_reset_n,
    input wire logic [7:0]                i_sfr_page,
    input wire logic [7:0]                i_sfr_addr,
    input wire logic                      i_sfr_wr,
    input wire logic                      i_sfr_rd,
    input wire logic [7:0]                i_sfr_wdata,
    input wire logic                      o_sfr_sel,
    input wire logic [7:0]                o_sfr_rdata,
    input wire logic                      i_crossbar_global_en,
    input wire logic [`CRB_PIN_COUNT-1:0] i_pin_skip_mask,
    input wire logic                      i_spi_four_wire,
    input wire crb_pkg::crb_route_t       o_route,
    input wire crb_pkg::crb_pin_map_t     o_pin_map,
    input wire logic                      o_assign_overflow
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    // pins carrying one function code
    function automatic int cnt(crb_pkg::crb_pin_map_t m, crb_pkg::crb_func_t f);
        cnt = 0;
        for (int k = 0; k < `CRB_PIN_COUNT; k++)
            cnt += (m[k] == f);
    endfunction : cnt
    property p_sel;
        o_sfr_sel == (i_sfr_page == 8'h0F && (i_sfr_addr == 8'hE1 || i_sfr_addr == 8'hE2));
    endproperty
    a_sel: assert property (p_sel) else $error("select decode wrong");
    property p_off;
        !i_crossbar_global_en |=> o_route == '0 && o_pin_map == '0;
    endproperty
    a_off: assert property (p_off) else $error("routing while crossbar off");
    property p_unmap;
        i_sfr_rd && !o_sfr_sel |=> o_sfr_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold;
        !i_sfr_rd |=> $stable(o_sfr_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_uart;
        o_route.uart_a_route_en |-> o_pin_map[4] == crb_pkg::CRB_FN_UART_TX
            && o_pin_map[5] == crb_pkg::CRB_FN_UART_RX;
    endproperty
    a_uart: assert property (p_uart) else $error("uart not on fixed pins");
    property p_can;
        o_route.can_route_en |-> o_pin_map[6] == crb_pkg::CRB_FN_CAN_TX
            && o_pin_map[7] == crb_pkg::CRB_FN_CAN_RX;
    endproperty
    a_can: assert property (p_can) else $error("can not on fixed pins");
    property p_spi;
        o_route.serial_periph_route_en && !o_assign_overflow |->
            cnt(o_pin_map, crb_pkg::CRB_FN_SPI_SCK) + cnt(o_pin_map, crb_pkg::CRB_FN_SPI_MISO)
            + cnt(o_pin_map, crb_pkg::CRB_FN_SPI_MOSI) + cnt(o_pin_map, crb_pkg::CRB_FN_SPI_NSS)
            == ($past(i_spi_four_wire) ? 4 : 3);
    endproperty
    a_spi: assert property (p_spi) else $error("spi pin count wrong");
    property p_cmp;
        !o_route.cmp1_async_out_en |-> cnt(o_pin_map, crb_pkg::CRB_FN_CMP1_ASY) == 0;
    endproperty
    a_cmp: assert property (p_cmp) else $error("disabled signal on a pin");
endmodule : crb_route_sva
bind crb_crossbar_route_enables crb_route_sva crb_route_sva_i (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_sfr_page(i_sfr_page), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_sel(o_sfr_sel), .o_sfr_rdata(o_sfr_rdata), .o_route(o_route),
    .i_crossbar_global_en(i_crossbar_global_en), .i_pin_skip_mask(i_pin_skip_mask),
    .i_spi_four_wire(i_spi_four_wire), .o_pin_map(o_pin_map),
    .o_assign_overflow(o_assign_overflow));
`default_nettype wire

// ### tb/crb_crossbar_route_enables_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "crb_map.svh"
module crb_crossbar_route_enables_tb;
    logic                      clk = 1'b0, rst_n = 1'b0;
    logic [7:0]                page = 8'h0F, addr = 8'h00, wdata = 8'h00, rdata, d;
    logic                      wr = 1'b0, rd = 1'b0, en = 1'b0, fw = 1'b0, sel, ovf;
    logic [`CRB_PIN_COUNT-1:0] skip = '0;
    crb_pkg::crb_route_t       route;
    crb_pkg::crb_pin_map_t     pmap, m;
    int                        n_fail = 0, n_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    // hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    crb_crossbar_route_enables crb_crossbar_route_enables_i (.i_core_clk(clk),
        .i_reset_n(rst_n), .i_sfr_page(page), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_sel(sel), .o_sfr_rdata(rdata),
        .i_crossbar_global_en(en), .i_pin_skip_mask(skip), .i_spi_four_wire(fw),
        .o_route(route), .o_pin_map(pmap), .o_assign_overflow(ovf));
    // ------------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    task setup(input logic e, input logic [15:0] s, input logic f);
        @(posedge clk);
        en   <= e;
        skip <= s;
        fw   <= f;
    endtask : setup
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    // bit 0 reserved, module count 111 routes none
    function automatic logic [17:0] exp_b(logic [7:0] b);
        exp_b = {8'h00, b[7:5], (b[4:2] == 3'h7) ? 6'h00 : 6'h3F >> (6 - b[4:2]), b[1]};
    endfunction : exp_b
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_regs;
        rreg(8'hE1);
        chk("a_reset", d, 8'h00);
        chk("sel_a", sel, 1'b1);
        rreg(8'hE2);
        chk("b_reset", d, 8'h00);
        chk("map_reset", pmap, '0);
        wreg(8'hE1, 8'hFF);
        wreg(8'hE2, 8'hFF);
        rreg(8'hE1);
        chk("a_rw", d, 8'hFF);
        rreg(8'hE2);
        chk("b_rw", d, 8'hFE);
        @(posedge clk) page <= 8'h0E;
        wreg(8'hE1, 8'h00);
        @(posedge clk) page <= 8'h0F;
        rreg(8'hE1);
        chk("a_page", d, 8'hFF);
        rreg(8'hE3);
        chk("unmapped", d, 8'h00);
        chk("sel_none", sel, 1'b0);
        settle();
        chk("route_off", route, '0);
    endtask : t_regs
    task t_fields;
        setup(1'b1, 16'h0000, 1'b0);
        wreg(8'hE2, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wreg(8'hE1, 8'h01 << i);
            settle();
            chk("route_a", route, {8'h01 << i, 10'h000});
        end
        wreg(8'hE1, 8'h00);
        for (int j = 0; j < 16; j++) begin
            d = (j < 8) ? 8'h01 << j : {3'h0, 3'(j), 2'h0};
            wreg(8'hE2, d);
            settle();
            chk("route_b", route, exp_b(d));
        end
    endtask : t_fields
    task t_pins;
        setup(1'b1, 16'hFFFF, 1'b0);
        wreg(8'hE2, 8'h00);
        wreg(8'hE1, 8'h03);
        settle();
        m = '0;
        m[4] = crb_pkg::CRB_FN_UART_TX;
        m[5] = crb_pkg::CRB_FN_UART_RX;
        m[6] = crb_pkg::CRB_FN_CAN_TX;
        m[7] = crb_pkg::CRB_FN_CAN_RX;
        chk("map_fixed", pmap, m);
        setup(1'b1, 16'h0026, 1'b1);
        wreg(8'hE1, 8'h06);
        settle();
        m[0] = crb_pkg::CRB_FN_SPI_SCK;
        m[3] = crb_pkg::CRB_FN_SPI_MISO;
        m[4] = crb_pkg::CRB_FN_SPI_MOSI;
        m[5] = crb_pkg::CRB_FN_GPIO;
        m[8] = crb_pkg::CRB_FN_SPI_NSS;
        chk("map_spi4", pmap, m);
        setup(1'b1, 16'h0026, 1'b0);
        settle();
        m[8] = crb_pkg::CRB_FN_GPIO;
        chk("map_spi3", pmap, m);
        setup(1'b1, 16'h00F0, 1'b0);
        wreg(8'hE1, 8'h00);
        wreg(8'hE2, 8'h1A);
        settle();
        m = '0;
        m[0] = crb_pkg::CRB_FN_SYSCLK;
        for (int k = 0; k < 6; k++)
            m[(k < 3) ? k + 1 : k + 5] = crb_pkg::crb_func_t'(5'h10 + 5'(k));
        chk("map_mods", pmap, m);
        chk("no_overflow", ovf, 1'b0);
        // every pin skipped: sysclk and module outputs find no pin
        setup(1'b1, 16'hFFFF, 1'b0);
        settle();
        chk("overflow", ovf, 1'b1);
        setup(1'b0, 16'h00F0, 1'b0);
        settle();
        chk("map_off", pmap, '0);
        chk("overflow_off", ovf, 1'b0);
    endtask : t_pins
    // reset in mid-run must clear both registers again
    task t_reset;
        wreg(8'hE1, 8'h81);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        rreg(8'hE1);
        chk("a_mid_reset", d, 8'h00);
        rreg(8'hE2);
        chk("b_mid_reset", d, 8'h00);
        chk("map_mid_reset", pmap, '0);
    endtask : t_reset
    task close_out;
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_fields();
        t_pins();
        t_reset();
        close_out();
    end
endmodule : crb_crossbar_route_enables_tb
`default_nettype wire
